// ---- include/coes_pkg.sv ----
package coes_pkg;
    // Output count and enable pin span
    localparam int NUM_OUT       = 20;
    localparam int PIN_FIRST_OUT = 5;
    localparam int PIN_LAST_OUT  = 12;
    localparam int NUM_PINS      = PIN_LAST_OUT - PIN_FIRST_OUT + 1;
    // Pin vector positions of the shared side-band functions
    localparam int SB_DATA_BIT   = 0;
    localparam int SB_CLK_BIT    = 1;
    localparam int SB_STROBE_BIT = 5;
    // SMBus byte map
    localparam logic [3:0] BYTE_EN0    = 4'h0;
    localparam logic [3:0] BYTE_EN1    = 4'h1;
    localparam logic [3:0] BYTE_EN2    = 4'h2;
    localparam logic [3:0] BYTE_STATUS = 4'h4;
    localparam logic [3:0] BYTE_MASK0  = 4'h8;
    localparam logic [3:0] BYTE_MASK1  = 4'h9;
    localparam logic [3:0] BYTE_MASK2  = 4'ha;
    localparam int STATUS_MODE_BIT     = 0;
    // Reset values and the mask of implemented bits
    localparam logic [NUM_OUT-1:0] OUTREG_RESET = 20'hfffff;
    localparam logic [23:0]        SMB_EN_RESET = 24'h0fffff;
    localparam logic [23:0]        MASK_RESET   = 24'h000000;
    localparam logic [23:0]        BYTES_USED   = 24'h0fffff;
    // Timing
    localparam longint MCLK_HZ        = 40_000_000;
    localparam longint SB_CLK_MAX_HZ  = 10_000_000;
    localparam int SB_HALF_CYC = int'((MCLK_HZ + 2 * SB_CLK_MAX_HZ - 1)
                                      / (2 * SB_CLK_MAX_HZ));
    localparam int OE_LAT_TYP_CLK = 5;
    localparam int OE_LAT_MAX_CLK = 10;
endpackage

// ---- include/coes_sb_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Eight enable pins, bit k is the pin of output 5+k
interface coes_sb_if;
    logic [coes_pkg::NUM_PINS-1:0] oePinN;
    modport device (input oePinN);
    modport host (output oePinN);
endinterface
`default_nettype wire

// ---- hw/coes_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module coes_host (
    input  wire logic                         mclk,
    input  wire logic                         arst_n,
    input  wire logic                         clkEn,
    input  wire logic                         sidebandMode,
    input  wire logic [coes_pkg::NUM_PINS-1:0] directEnableN,
    input  wire logic                         cmdValid,
    input  wire logic [coes_pkg::NUM_OUT-1:0]  cmdBits,
    output logic                              cmdReady,
    coes_sb_if.host                           sb
);
    typedef enum logic [2:0] {
        COES_IDLE, COES_SETUP, COES_CLKHI, COES_CLKLO, COES_PARK, COES_LOAD
    } coes_hstate_e;

    coes_hstate_e                  state_q;
    logic [coes_pkg::NUM_PINS-1:0] pins_q;
    logic [coes_pkg::NUM_OUT-1:0]  data_q;
    logic [4:0]                    bitCnt_q;
    logic [3:0]                    half_q;
    logic                          ready_q;
    logic                          halfDone;

    localparam logic [3:0] HALF_LAST = 4'(coes_pkg::SB_HALF_CYC - 1);
    localparam logic [4:0] BIT_LAST  = 5'(coes_pkg::NUM_OUT - 1);

    assign sb.oePinN = pins_q;
    assign cmdReady  = ready_q;
    assign halfDone  = (half_q == HALF_LAST);

    // Phase timer: each clock half lasts SB_HALF_CYC mclk cycles
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            half_q <= 4'h0;
        end else if (clkEn) begin
            if (state_q == COES_IDLE || halfDone) begin
                half_q <= 4'h0;
            end else begin
                half_q <= half_q + 4'h1;
            end
        end
    end

    // Serial sequencer; clock derived by division keeps it at or below 10 MHz
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q  <= COES_IDLE;
            pins_q   <= '0;
            data_q   <= '0;
            bitCnt_q <= 5'h0;
            ready_q  <= 1'b1;
        end else if (clkEn) begin
            unique case (state_q)
                COES_IDLE: begin
                    pins_q <= directEnableN;
                    if (sidebandMode) begin
                        pins_q[coes_pkg::SB_CLK_BIT]    <= 1'b0;
                        pins_q[coes_pkg::SB_STROBE_BIT] <= 1'b0;
                        if (cmdValid && ready_q) begin
                            // Strobe rises before any clock edge
                            pins_q[coes_pkg::SB_STROBE_BIT] <= 1'b1;
                            pins_q[coes_pkg::SB_DATA_BIT]   <= cmdBits[0];
                            data_q   <= cmdBits;
                            bitCnt_q <= 5'h0;
                            ready_q  <= 1'b0;
                            state_q  <= COES_SETUP;
                        end
                    end
                end
                COES_SETUP, COES_CLKLO: begin
                    if (halfDone) begin
                        pins_q[coes_pkg::SB_CLK_BIT] <= 1'b1;
                        state_q <= COES_CLKHI;
                    end
                end
                COES_CLKHI: begin
                    if (halfDone) begin
                        pins_q[coes_pkg::SB_CLK_BIT] <= 1'b0;
                        if (bitCnt_q == BIT_LAST) begin
                            state_q <= COES_PARK;
                        end else begin
                            // New bit on the falling edge, bit 0 first
                            pins_q[coes_pkg::SB_DATA_BIT] <= data_q[1];
                            data_q   <= data_q >> 1;
                            bitCnt_q <= bitCnt_q + 5'h1;
                            state_q  <= COES_CLKLO;
                        end
                    end
                end
                COES_PARK: begin
                    if (halfDone) begin
                        pins_q[coes_pkg::SB_STROBE_BIT] <= 1'b0;
                        state_q <= COES_LOAD;
                    end
                end
                COES_LOAD: begin
                    if (halfDone) begin
                        ready_q <= 1'b1;
                        state_q <= COES_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- hw/coes_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module coes_device (
    input  wire logic                        mclk,
    input  wire logic                        arst_n,
    input  wire logic                        clkEn,
    input  wire logic                        interfaceSelectStrap,
    input  wire logic                        powerGoodPowerdownN,
    input  wire logic                        smbWrite,
    input  wire logic                        smbRead,
    input  wire logic [3:0]                  smbByteSel,
    input  wire logic [7:0]                  smbWrData,
    output logic [7:0]                       smbRdData,
    output logic                             sidebandActive,
    output logic [coes_pkg::NUM_OUT-1:0]     outRunning,
    coes_sb_if.device                        sb
);
    localparam int N = coes_pkg::NUM_OUT;
    localparam int P = coes_pkg::NUM_PINS;

    // Link pins; pins 7,8,9,11,12 have no side-band meaning
    logic          sbClk;
    logic          sbData;
    logic          sbStrobe;

    // Link domains: shift clock and strobe fall
    logic [N-1:0]  shift_q;
    logic [N-1:0]  outReg_q;
    logic          loadTgl_q;

    // Synchronisers into mclk
    logic          strapS1_q;
    logic          strapS2_q;
    logic          pgS1_q;
    logic          pgS2_q;
    logic [P-1:0]  pinS1_q;
    logic [P-1:0]  pinS2_q;
    logic          tglS1_q;
    logic          tglS2_q;
    logic          tglS3_q;

    // Control state
    logic          started_q;
    logic          mode_q;
    logic [N-1:0]  sbOut_q;
    logic [23:0]   smbEn_q;
    logic [23:0]   mask_q;
    logic [N-1:0]  enable_d;
    logic [N-1:0]  decision_q;
    logic [N-1:0]  outRun_q;
    logic [7:0]    rdData_q;

    assign sbData   = sb.oePinN[coes_pkg::SB_DATA_BIT];
    assign sbClk    = sb.oePinN[coes_pkg::SB_CLK_BIT];
    assign sbStrobe = sb.oePinN[coes_pkg::SB_STROBE_BIT];

    assign smbRdData      = rdData_q;
    assign sidebandActive = mode_q;
    assign outRunning     = outRun_q;

    // Shift on clock rise only while the strobe selects this device;
    // first bit ends up in position 0 after twenty shifts
    always_ff @(posedge sbClk or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= coes_pkg::OUTREG_RESET;
        end else if (sbStrobe) begin
            shift_q <= {sbData, shift_q[N-1:1]};
        end
    end

    // Strobe fall loads the whole word; clock is parked so shift is
    // stable here. No power gating: preload before power-good works
    always_ff @(negedge sbStrobe or negedge arst_n) begin
        if (!arst_n) begin
            outReg_q  <= coes_pkg::OUTREG_RESET;
            loadTgl_q <= 1'b0;
        end else begin
            outReg_q  <= shift_q;
            loadTgl_q <= ~loadTgl_q;
        end
    end

    // Two-stage synchronisers for pins and the load toggle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            strapS1_q <= 1'b0;
            strapS2_q <= 1'b0;
            pgS1_q    <= 1'b0;
            pgS2_q    <= 1'b0;
            pinS1_q   <= '0;
            pinS2_q   <= '0;
            tglS1_q   <= 1'b0;
            tglS2_q   <= 1'b0;
            tglS3_q   <= 1'b0;
        end else if (clkEn) begin
            strapS1_q <= interfaceSelectStrap;
            strapS2_q <= strapS1_q;
            pgS1_q    <= powerGoodPowerdownN;
            pgS2_q    <= pgS1_q;
            pinS1_q   <= sb.oePinN;
            pinS2_q   <= pinS1_q;
            tglS1_q   <= loadTgl_q;
            tglS2_q   <= tglS1_q;
            tglS3_q   <= tglS2_q;
        end
    end

    // Strap tracked until first power-good, then frozen for good
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            started_q <= 1'b0;
            mode_q    <= 1'b0;
        end else if (clkEn) begin
            if (!started_q) begin
                mode_q <= strapS2_q;
                if (pgS2_q) begin
                    started_q <= 1'b1;
                end
            end
        end
    end

    // Load word capture; toggle proves the word settled long ago
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sbOut_q <= coes_pkg::OUTREG_RESET;
        end else if (clkEn) begin
            if (tglS2_q != tglS3_q) begin
                sbOut_q <= outReg_q;
            end
        end
    end

    // SMBus byte writes; mask bytes locked out while powered down
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            smbEn_q <= coes_pkg::SMB_EN_RESET;
            mask_q  <= coes_pkg::MASK_RESET;
        end else if (clkEn && smbWrite) begin
            unique case (smbByteSel)
                coes_pkg::BYTE_EN0: smbEn_q[7:0]   <= smbWrData;
                coes_pkg::BYTE_EN1: smbEn_q[15:8]  <= smbWrData;
                coes_pkg::BYTE_EN2: smbEn_q[23:16] <=
                    smbWrData & coes_pkg::BYTES_USED[23:16];
                coes_pkg::BYTE_MASK0: begin
                    if (pgS2_q) begin
                        mask_q[7:0] <= smbWrData;
                    end
                end
                coes_pkg::BYTE_MASK1: begin
                    if (pgS2_q) begin
                        mask_q[15:8] <= smbWrData;
                    end
                end
                coes_pkg::BYTE_MASK2: begin
                    if (pgS2_q) begin
                        mask_q[23:16] <=
                            smbWrData & coes_pkg::BYTES_USED[23:16];
                    end
                end
                default: ; // Other bytes are not writable here
            endcase
        end
    end

    // SMBus read-back, unmapped bytes read zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_q <= 8'h00;
        end else if (clkEn && smbRead) begin
            rdData_q <= 8'h00;
            unique case (smbByteSel)
                coes_pkg::BYTE_EN0:    rdData_q <= smbEn_q[7:0];
                coes_pkg::BYTE_EN1:    rdData_q <= smbEn_q[15:8];
                coes_pkg::BYTE_EN2:    rdData_q <= smbEn_q[23:16];
                coes_pkg::BYTE_STATUS: begin
                    rdData_q[coes_pkg::STATUS_MODE_BIT] <= mode_q;
                end
                coes_pkg::BYTE_MASK0: begin
                    if (pgS2_q) begin
                        rdData_q <= mask_q[7:0];
                    end
                end
                coes_pkg::BYTE_MASK1: begin
                    if (pgS2_q) begin
                        rdData_q <= mask_q[15:8];
                    end
                end
                coes_pkg::BYTE_MASK2: begin
                    if (pgS2_q) begin
                        rdData_q <= mask_q[23:16];
                    end
                end
                default: ; // Reads zero
            endcase
        end
    end

    // Per-output enable decision for the selected method only
    for (genvar i = 0; i < N; i++) begin : g_out
        if (i >= coes_pkg::PIN_FIRST_OUT && i <= coes_pkg::PIN_LAST_OUT)
        begin : g_pin
            // Pin high disables; outputs 7-9, 11 and 12 pins unused in side-band
            always_comb begin
                if (mode_q) begin
                    enable_d[i] = sbOut_q[i] | mask_q[i];
                end else begin
                    enable_d[i] = smbEn_q[i] &
                        ~pinS2_q[i - coes_pkg::PIN_FIRST_OUT];
                end
            end
        end else begin : g_nopin
            always_comb begin
                if (mode_q) begin
                    enable_d[i] = sbOut_q[i] | mask_q[i];
                end else begin
                    enable_d[i] = smbEn_q[i];
                end
            end
        end
    end

    // Shared two-stage enable synchroniser; registered so each output
    // changes cleanly, about four clocks after a pin change
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            decision_q <= '0;
            outRun_q   <= '0;
        end else if (clkEn) begin
            // Power-down or not yet started forces all outputs off
            decision_q <= (started_q && pgS2_q) ? enable_d : '0;
            outRun_q   <= decision_q;
        end
    end
endmodule
`default_nettype wire

// ---- verif/coes_sb_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module coes_sb_chk (
    input wire logic                          mclk,
    input wire logic                          arst_n,
    input wire logic                          sidebandMode,
    input wire logic [coes_pkg::NUM_PINS-1:0] oePinN
);
    logic       sDat;
    logic       sClk;
    logic       sLd;
    logic [5:0] rises_q;

    // Shared pins in their side-band roles
    assign sDat = oePinN[coes_pkg::SB_DATA_BIT];
    assign sClk = oePinN[coes_pkg::SB_CLK_BIT];
    assign sLd  = oePinN[coes_pkg::SB_STROBE_BIT];

    // Traditional mode uses the same pins as levels, so nothing applies
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n || !sidebandMode);

    // Serial clock rises inside the current frame
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rises_q <= 6'h0;
        end else if (!sLd) begin
            rises_q <= 6'h0;
        end else if ($rose(sClk)) begin
            rises_q <= rises_q + 6'h1;
        end
    end

    a_clk_in_frame: assert property (sClk |-> sLd)
        else $error("serial clock high with strobe low");
    a_strobe_leads: assert property ($rose(sClk) |-> $past(sLd, 2))
        else $error("clock rose too soon after strobe");
    a_high_time: assert property ($rose(sClk) |=> sClk)
        else $error("serial clock high phase too short");
    a_low_time: assert property ($fell(sClk) && sLd |=> !sClk)
        else $error("serial clock low phase too short");
    a_data_steady: assert property ($rose(sClk) |-> $stable(sDat))
        else $error("data moved at clock rise");
    a_twenty_bits: assert property ($fell(sLd) |-> rises_q == 6'h14)
        else $error("frame not twenty clocks");
    a_park_low: assert property ($fell(sLd) |-> !$past(sClk, 2))
        else $error("clock not parked before strobe drop");
    a_frame_len: assert property ($rose(sLd) |-> ##[76:90] $fell(sLd))
        else $error("frame length out of range");

    c_frame: cover property ($fell(sLd));
    c_full: cover property (rises_q == 6'h14);
    c_rise: cover property ($rose(sClk));
endmodule
`default_nettype wire

// ---- verif/clock_output_enable_sideband_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_output_enable_sideband_tb;
    logic        mclk;
    logic        arst_n;
    logic        strap;
    logic        pg;
    logic        smbWrite;
    logic        smbRead;
    logic [3:0]  smbSel;
    logic [7:0]  smbWd;
    logic [7:0]  smbRd;
    logic [19:0] outRun;
    logic [19:0] outRun2;
    logic        sbMode;
    logic        sbActive;
    logic [7:0]  dirEnN;
    logic        cmdValid;
    logic [19:0] cmdBits;
    logic        cmdReady;
    int          num_errors;
    int          comparisons;

    coes_sb_if u_sb();
    coes_sb_if u_sb2();

    coes_host u_coes_host (.mclk(mclk), .arst_n(arst_n), .clkEn(1'b1),
        .sidebandMode(sbMode), .directEnableN(dirEnN),
        .cmdValid(cmdValid), .cmdBits(cmdBits), .cmdReady(cmdReady),
        .sb(u_sb));
    coes_device u_coes_device (.mclk(mclk), .arst_n(arst_n), .clkEn(1'b1),
        .interfaceSelectStrap(strap), .powerGoodPowerdownN(pg),
        .smbWrite(smbWrite), .smbRead(smbRead), .smbByteSel(smbSel),
        .smbWrData(smbWd), .smbRdData(smbRd), .sidebandActive(sbActive),
        .outRunning(outRun), .sb(u_sb));
    // Second device on bench-driven pins, to break host rules on purpose
    coes_device u_coes_device_b (.mclk(mclk), .arst_n(arst_n),
        .clkEn(1'b1), .interfaceSelectStrap(strap),
        .powerGoodPowerdownN(pg), .smbWrite(smbWrite), .smbRead(smbRead),
        .smbByteSel(smbSel), .smbWrData(smbWd), .smbRdData(),
        .sidebandActive(), .outRunning(outRun2), .sb(u_sb2));
    coes_sb_chk u_coes_sb_chk (.mclk(mclk), .arst_n(arst_n),
        .sidebandMode(sbMode), .oePinN(u_sb.oePinN));

    // Free-running 40 MHz clock
    always #12.5 mclk = ~mclk;

    task automatic tally_and_finish();
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic s);
        arst_n <= 1'b0;
        strap  <= s;
        sbMode <= s;
        pg     <= 1'b0;
        cyc(3);
        arst_n <= 1'b1;
        cyc(2);
    endtask

    task automatic smb_wr(input logic [3:0] b, input logic [7:0] d);
        smbWrite <= 1'b1;
        smbSel   <= b;
        smbWd    <= d;
        cyc(1);
        smbWrite <= 1'b0;
        cyc(1);
    endtask

    // Read data stands after the take edge, so the two spare edges are safe
    task automatic smb_rd(input logic [3:0] b, input logic [7:0] exp);
        smbRead <= 1'b1;
        smbSel  <= b;
        cyc(1);
        smbRead <= 1'b0;
        cyc(2);
        check({12'h0, smbRd}, {12'h0, exp});
    endtask

    task automatic host_send(input logic [19:0] w);
        int n;
        n = 0;
        cmdValid <= 1'b1;
        cmdBits  <= w;
        cyc(1);
        cmdValid <= 1'b0;
        cyc(1);
        while (cmdReady !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // Bench frame at 125 ns link period, phase unrelated to mclk
    task automatic bb_frame(input logic [19:0] w, input logic ld);
        #7;
        for (int i = 0; i < 20; i++) begin
            u_sb2.oePinN = {2'b00, ld, 4'h0, w[i]};
            #62.5;
            u_sb2.oePinN[1] = 1'b1;
            #62.5;
        end
        u_sb2.oePinN = {2'b00, ld, 4'h0, ~w[19]};
        #62.5;
        u_sb2.oePinN = 8'h00;
        #62.5;
    endtask

    task automatic t_trad();
        do_reset(1'b0);
        check(outRun, 20'h0);
        pg <= 1'b1;
        cyc(10);
        check(outRun, 20'hfffff);
        check({19'h0, sbActive}, 20'h0);
        smb_rd(4'h4, 8'h00);
        smb_rd(4'h2, 8'h0f);
        smb_rd(4'h3, 8'h00);
        dirEnN <= 8'h04;
        cyc(10);
        check(outRun, 20'hfff7f);
        smb_wr(4'h0, 8'hfe);
        cyc(10);
        check(outRun, 20'hfff7e);
        pg <= 1'b0;
        cyc(10);
        check(outRun, 20'h0);
        dirEnN <= 8'h00;
    endtask

    task automatic t_sideband();
        do_reset(1'b1);
        host_send(20'h5a5a5);
        cyc(10);
        check(outRun, 20'h0);
        smb_wr(4'h8, 8'hff);
        pg <= 1'b1;
        cyc(10);
        check(outRun, 20'h5a5a5);
        // Untouched second device still shows its power-up word
        check(outRun2, 20'hfffff);
        check({19'h0, sbActive}, 20'h1);
        smb_rd(4'h8, 8'h00);
        smb_rd(4'h4, 8'h01);
    endtask

    task automatic t_fault();
        bb_frame(20'h3c3c3, 1'b1);
        cyc(10);
        check(outRun2, 20'h3c3c3);
        bb_frame(20'hfffff, 1'b0);
        u_sb2.oePinN = 8'h20;
        #62.5;
        u_sb2.oePinN = 8'h00;
        cyc(10);
        check(outRun2, 20'h3c3c3);
    endtask

    task automatic t_mask();
        smb_wr(4'h8, 8'h81);
        smb_wr(4'ha, 8'h08);
        smb_rd(4'ha, 8'h08);
        dirEnN <= 8'hdc;
        host_send(20'h00000);
        cyc(10);
        check(outRun, 20'h80081);
        host_send(20'h0f00f);
        cyc(10);
        check(outRun, 20'h8f08f);
        // Power-down locks the masks both ways and stops the outputs
        pg <= 1'b0;
        cyc(4);
        smb_wr(4'h8, 8'h00);
        smb_rd(4'h8, 8'h00);
        check(outRun, 20'h0);
        pg <= 1'b1;
        cyc(4);
        smb_rd(4'h8, 8'h81);
        check(outRun, 20'h8f08f);
    endtask

    // Main sequence
    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        strap = 1'b0;
        sbMode = 1'b0;
        pg = 1'b0;
        smbWrite = 1'b0;
        smbRead = 1'b0;
        smbSel = 4'h0;
        smbWd = 8'h00;
        dirEnN = 8'h00;
        cmdValid = 1'b0;
        cmdBits = 20'h0;
        u_sb2.oePinN = 8'h00;
        num_errors = 0;
        comparisons = 0;
        t_trad();
        t_sideband();
        t_fault();
        t_mask();
        tally_and_finish();
    end
endmodule
`default_nettype wire
